// ===== verilog/prio_defines.svh
// Constants for the priority interrupt command and status block.
`ifndef PRIO_DEFINES_SVH
`define PRIO_DEFINES_SVH

`define PRIO_CMD_ADDR     8'he6
`define PRIO_MASK_ADDR    8'he7

`define PRIO_INIT_BIT     4
`define PRIO_SEL_BIT      3
`define PRIO_OP_HI        7
`define PRIO_OP_LO        5
`define PRIO_LINE_HI      2
`define PRIO_LINE_LO      0
`define PRIO_SMM_HI       6
`define PRIO_SMM_LO       5
`define PRIO_RD_HI        1
`define PRIO_RD_LO        0
`define PRIO_SEL_TOP_BIT  7

`define PRIO_OP_CLR_ROT   3'h0
`define PRIO_OP_NS_END     3'h1
`define PRIO_OP_SP_END     3'h3
`define PRIO_OP_ROT_NS_END 3'h5
`define PRIO_OP_SET_PRIO   3'h6
`define PRIO_OP_ROT_SP_END 3'h7

`define PRIO_SMM_SET      2'h3
`define PRIO_SMM_CLR      2'h2
`define PRIO_RD_PEND      2'h2
`define PRIO_RD_SERV      2'h3

`define PRIO_MASK_RST     8'hff
`define PRIO_BOTTOM_RST   3'h7
`define PRIO_BYTE_ZERO    8'h00
`define PRIO_LINE_ZERO    3'h0

`endif

// ===== verilog/prio_pkg.sv
// Types shared by the priority interrupt command and status block.
package prio_pkg;
  typedef logic [7:0] prio_byte_t;
  typedef logic [2:0] prio_line_t;
  typedef logic [3:0] prio_rank_t;
  typedef enum logic {PRIO_SEL_PEND, PRIO_SEL_SERV} prio_sel_e;
endpackage

// ===== verilog/prio_res_if.sv
// Interface between the command logic and the priority resolver.
`timescale 1ns/1ps
`default_nettype none
interface prio_res_if;
  import prio_pkg::*;
  prio_line_t bottom;
  prio_byte_t serv_vec;
  prio_byte_t req_vec;
  logic       serv_hit;
  prio_line_t serv_line;
  prio_rank_t serv_rank;
  logic       req_hit;
  prio_line_t req_line;
  prio_rank_t req_rank;
  modport owner    (output bottom, serv_vec, req_vec,
                    input serv_hit, serv_line, serv_rank, req_hit, req_line, req_rank);
  modport resolver (input bottom, serv_vec, req_vec,
                    output serv_hit, serv_line, serv_rank, req_hit, req_line, req_rank);
endinterface
`default_nettype wire

// ===== verilog/prio_resolver.sv
// Rotating priority resolver: finds the highest priority set bit of two vectors.
`timescale 1ns/1ps
`default_nettype none
module prio_resolver
  import prio_pkg::*;
(
  prio_res_if.resolver rif
);

  prio_byte_t serv_rot;
  prio_byte_t req_rot;

  // Rank k holds line bottom+1+k, so rank 0 is the line just above the bottom.
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_rot
      assign serv_rot[k] = rif.serv_vec[3'(rif.bottom + 3'(k + 1))];
      assign req_rot[k] = rif.req_vec[3'(rif.bottom + 3'(k + 1))];
    end
  endgenerate

  // Returns the lowest set rank; rank 8 means nothing set.
  function automatic prio_rank_t first_rank(input prio_byte_t v);
    prio_rank_t r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    rif.serv_rank = first_rank(serv_rot);
    rif.req_rank  = first_rank(req_rot);
    rif.serv_hit  = ~rif.serv_rank[3];
    rif.req_hit   = ~rif.req_rank[3];
    rif.serv_line = 3'(rif.bottom + 3'h1 + rif.serv_rank[2:0]);
    rif.req_line = 3'(rif.bottom + 3'h1 + rif.req_rank[2:0]);
  end

endmodule
`default_nettype wire

// ===== verilog/prio_cmd_status.sv
// Command and status logic of an eight-line priority interrupt unit.
`timescale 1ns/1ps
`default_nettype none
`include "prio_defines.svh"
module prio_cmd_status
  import prio_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [7:0] IO_ADDR,
  input  wire logic       IO_WR,
  input  wire logic       IO_RD,
  input  wire logic [7:0] IO_WDATA,
  output logic      [7:0] IO_RDATA,
  input  wire logic [7:0] REQ_LINES,
  input  wire logic       INT_ACK,
  output logic            INT_REQ,
  output logic      [2:0] ACK_LINE
);

  prio_byte_t pend_q;
  prio_byte_t serv_q;
  prio_byte_t serv_d;
  prio_byte_t mask_q;
  prio_line_t bottom_q;
  prio_line_t bottom_d;
  prio_sel_e  sel_q;
  logic       smm_q;
  logic       rot_q;
  logic       rot_d;
  logic       irq_q;
  prio_byte_t rdata_q;
  prio_line_t ack_line_q;

  logic       cmd_wr;
  logic       mask_wr;
  logic       op_word;
  logic       sel_word;
  logic [2:0] op;
  prio_line_t word_line;
  prio_byte_t serv_clr;
  prio_byte_t serv_set;
  logic       irq_d;

  prio_res_if rif ();

  prio_resolver u_resolver (
    .rif (rif)
  );

  // Port decode. Words with bit 4 set are initialization words, which this
  // block does not handle, so they fall through as unrecognised.
  assign cmd_wr    = IO_WR && (IO_ADDR == `PRIO_CMD_ADDR);
  assign mask_wr   = IO_WR && (IO_ADDR == `PRIO_MASK_ADDR);
  assign op_word   = cmd_wr && !IO_WDATA[`PRIO_INIT_BIT] && !IO_WDATA[`PRIO_SEL_BIT];
  assign sel_word  = cmd_wr && !IO_WDATA[`PRIO_INIT_BIT] && IO_WDATA[`PRIO_SEL_BIT] &&
                     !IO_WDATA[`PRIO_SEL_TOP_BIT];
  assign op        = IO_WDATA[`PRIO_OP_HI:`PRIO_OP_LO];
  assign word_line = IO_WDATA[`PRIO_LINE_HI:`PRIO_LINE_LO];

  // Resolver inputs. In special mask mode the lines already in service are
  // taken out of the request vector instead of blocking lower lines.
  assign rif.bottom  = bottom_q;
  assign rif.serv_vec = serv_q;
  assign rif.req_vec = smm_q ? (pend_q & ~mask_q & ~serv_q) : (pend_q & ~mask_q);

  // Pending requests follow the lines every cycle.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pend_q <= `PRIO_BYTE_ZERO;
    end else begin
      pend_q <= REQ_LINES;
    end
  end

  // End-of-interrupt decode and the rotation that goes with it.
  always_comb begin
    serv_clr = `PRIO_BYTE_ZERO;
    bottom_d = bottom_q;
    rot_d    = rot_q;
    if (op_word) begin
      case (op)
        `PRIO_OP_NS_END: begin
          if (rif.serv_hit) begin
            serv_clr[rif.serv_line] = 1'b1;
            if (rot_q) begin
              bottom_d = rif.serv_line;
            end
          end
        end
        `PRIO_OP_ROT_NS_END: begin
          rot_d = 1'b1;
          if (rif.serv_hit) begin
            serv_clr[rif.serv_line] = 1'b1;
            bottom_d = rif.serv_line;
          end
        end
        `PRIO_OP_CLR_ROT: begin
          rot_d = 1'b0;
        end
        `PRIO_OP_SP_END: begin
          serv_clr[word_line] = 1'b1;
        end
        `PRIO_OP_ROT_SP_END: begin
          serv_clr[word_line] = 1'b1;
          bottom_d = word_line;
        end
        `PRIO_OP_SET_PRIO: begin
          bottom_d = word_line;
        end
        default: begin
          bottom_d = bottom_q;
        end
      endcase
    end
  end

  // An acknowledge marks the winning request as being serviced. A set in
  // the same cycle as a clear of that bit wins, so no service is lost.
  always_comb begin
    serv_set = `PRIO_BYTE_ZERO;
    if (INT_ACK && rif.req_hit) begin
      serv_set[rif.req_line] = 1'b1;
    end
    serv_d = (serv_q & ~serv_clr) | serv_set;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      serv_q <= `PRIO_BYTE_ZERO;
    end else begin
      serv_q <= serv_d;
    end
  end

  // Priority order; reset leaves line 7 at the bottom, which is fully nested.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bottom_q <= `PRIO_BOTTOM_RST;
      rot_q    <= 1'b0;
    end else begin
      bottom_q <= bottom_d;
      rot_q    <= rot_d;
    end
  end

  // Interrupt mask.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mask_q <= `PRIO_MASK_RST;
    end else if (mask_wr) begin
      mask_q <= IO_WDATA;
    end
  end

  // Read selection and special mask mode come from select words. A select
  // word that names neither register leaves the selection alone.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sel_q <= PRIO_SEL_PEND;
    end else if (sel_word) begin
      case (IO_WDATA[`PRIO_RD_HI:`PRIO_RD_LO])
        `PRIO_RD_PEND: sel_q <= PRIO_SEL_PEND;
        `PRIO_RD_SERV: sel_q <= PRIO_SEL_SERV;
        default:       sel_q <= sel_q;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      smm_q <= 1'b0;
    end else if (sel_word) begin
      case (IO_WDATA[`PRIO_SMM_HI:`PRIO_SMM_LO])
        `PRIO_SMM_SET: smm_q <= 1'b1;
        `PRIO_SMM_CLR: smm_q <= 1'b0;
        default:       smm_q <= smm_q;
      endcase
    end
  end

  // Read data is registered and holds until the next read. The selection is
  // not consumed by a read, so repeated reads give the same register.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_q <= `PRIO_BYTE_ZERO;
    end else if (IO_RD) begin
      if (IO_ADDR == `PRIO_CMD_ADDR) begin
        rdata_q <= (sel_q == PRIO_SEL_SERV) ? serv_q : pend_q;
      end else if (IO_ADDR == `PRIO_MASK_ADDR) begin
        rdata_q <= mask_q;
      end else begin
        rdata_q <= `PRIO_BYTE_ZERO;
      end
    end
  end

  // In nested mode a request must outrank every line in service; a line of
  // equal rank is the one being serviced and must not interrupt itself.
  always_comb begin
    if (smm_q) begin
      irq_d = rif.req_hit;
    end else begin
      irq_d = rif.req_hit && (!rif.serv_hit || (rif.req_rank < rif.serv_rank));
    end
  end

  // The request output lags the cause by one cycle to keep it glitch free.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_line_q <= `PRIO_LINE_ZERO;
    end else if (INT_ACK && rif.req_hit) begin
      ack_line_q <= rif.req_line;
    end
  end

  assign IO_RDATA = rdata_q;
  assign INT_REQ  = irq_q;
  assign ACK_LINE = ack_line_q;

endmodule
`default_nettype wire

// ===== verification/prio_cmd_sva.sv
// Port assertions for the priority interrupt command block.
`timescale 1ns/1ps
`default_nettype none
module prio_cmd_sva (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [7:0] IO_ADDR,
  input wire logic       IO_WR,
  input wire logic       IO_RD,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire logic [7:0] REQ_LINES,
  input wire logic       INT_ACK,
  input wire logic       INT_REQ,
  input wire logic [2:0] ACK_LINE
);
  logic [7:0] mask_q;
  always_ff @(posedge CLOCK) begin
    if (RST) mask_q <= 8'hff;
    else if (IO_WR && IO_ADDR == 8'he7) mask_q <= IO_WDATA;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_sel;
    IO_WR && IO_ADDR == 8'he6 && IO_WDATA == 8'h0a;
  endsequence
  sequence s_calm;
    !IO_WR && !INT_ACK && $stable(REQ_LINES);
  endsequence
  sel_read_a: assert property (s_sel ##1 IO_RD && IO_ADDR == 8'he6 |=>
    IO_RDATA == $past(REQ_LINES, 2)) else $error("pending read wrong");
  mask_read_a: assert property (IO_RD && IO_ADDR == 8'he7 |=> IO_RDATA == $past(mask_q))
    else $error("mask read wrong");
  unmapped_read_a: assert property (IO_RD && IO_ADDR[7:1] != 7'h73 |=> IO_RDATA == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$past(IO_RD) |-> $stable(IO_RDATA))
    else $error("read data moved");
  all_masked_a: assert property ($past(mask_q) == 8'hff |-> !INT_REQ)
    else $error("request while all masked");
  quiet_lines_a: assert property ($past(REQ_LINES, 2) == 8'h00 |-> !INT_REQ)
    else $error("request with no lines");
  rise_cause_a: assert property ($rose(INT_REQ) |->
    ($past(REQ_LINES, 2) & ~$past(mask_q)) != 8'h00) else $error("request without cause");
  ack_line_a: assert property (s_calm ##1 INT_ACK && INT_REQ && !IO_WR |=>
    ((($past(REQ_LINES, 2) & ~$past(mask_q)) >> ACK_LINE) & 8'h01) == 8'h01)
    else $error("taken line not eligible");
endmodule
bind prio_cmd_status prio_cmd_sva prio_cmd_sva_inst (.CLOCK(CLOCK), .RST(RST),
  .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA),
  .IO_RDATA(IO_RDATA), .REQ_LINES(REQ_LINES), .INT_ACK(INT_ACK), .INT_REQ(INT_REQ),
  .ACK_LINE(ACK_LINE));
`default_nettype wire

// ===== verification/prio_cpu_model.sv
// Processor side that acknowledges an interrupt request after a set delay.
`timescale 1ns/1ps
`default_nettype none
module prio_cpu_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic       int_req,
  output logic            int_ack
);
  logic [3:0] wait_q;
  // Rearmed when the request drops or ack_en is low, so one rise earns one acknowledge.
  always_ff @(posedge clock) begin
    int_ack <= 1'b0;
    if (rst || !int_req || !ack_en) begin
      wait_q <= 4'h0;
    end else if (wait_q == ack_dly) begin
      int_ack <= 1'b1;
      wait_q  <= 4'hf;
    end else if (wait_q != 4'hf) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/prio_cmd_status_tb.sv
// Self-checking bench for the priority interrupt command block.
`timescale 1ns/1ps
`default_nettype none
module prio_cmd_status_tb;
  import prio_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] io_addr = 8'h00;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] req_lines = 8'h00;
  logic       ack_en = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [7:0] io_rdata;
  logic       int_ack;
  logic       int_req;
  logic [2:0] ack_line;
  int         n_mismatch = 0;
  int         compares = 0;
  prio_cmd_status prio_cmd_status_inst (.CLOCK(clock), .RST(rst), .IO_ADDR(io_addr),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .REQ_LINES(req_lines), .INT_ACK(int_ack), .INT_REQ(int_req), .ACK_LINE(ack_line));
  prio_cpu_model prio_cpu_model_inst (.clock(clock), .rst(rst), .ack_en(ack_en),
    .ack_dly(ack_dly), .int_req(int_req), .int_ack(int_ack));
  always #2.5 clock = ~clock;
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input prio_byte_t exp, input prio_byte_t got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input prio_byte_t a, input prio_byte_t d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input prio_byte_t a, input prio_byte_t exp);
    io_addr = a;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    tick(1);
    chk($sformatf("read %h", a), exp, io_rdata);
  endtask
  // Select word and status read on consecutive edges, the tightest legal spacing.
  task automatic rsel(input prio_byte_t sel, input prio_byte_t exp);
    io_addr = 8'he6;
    io_wdata = sel;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    tick(1);
    chk("status", exp, io_rdata);
  endtask
  task automatic take(input logic [3:0] dly, input prio_line_t exp);
    int i;
    ack_dly = dly;
    ack_en = 1'b1;
    for (i = 0; i < 20 && int_ack !== 1'b1; i++) tick(1);
    if (i == 20) begin
      n_mismatch++;
      give_verdict();
    end
    ack_en = 1'b0;
    tick(1);
    chk("ack line", {5'h00, exp}, {5'h00, ack_line});
  endtask
  initial begin
    tick(8);
    rst = 1'b0;
    rd(8'he7, 8'hff);
    rd(8'he6, 8'h00);
    wr(8'he7, 8'h5a);
    wr(8'he5, 8'h33);
    rd(8'he7, 8'h5a);
    rd(8'he5, 8'h00);
    req_lines = 8'ha5;
    tick(1);
    rsel(8'h0a, 8'ha5);
    req_lines = 8'h3c;
    tick(1);
    rd(8'he6, 8'h3c);
    wr(8'he7, 8'hff);
    req_lines = 8'h0c;
    tick(3);
    chk("int req", 8'h00, {7'h00, int_req});
    wr(8'he7, 8'h00);
    take(4'h0, 3'h2);
    rsel(8'h0b, 8'h04);
    tick(2);
    chk("int req", 8'h00, {7'h00, int_req});
    wr(8'he6, 8'h68);
    take(4'h3, 3'h3);
    rd(8'he6, 8'h0c);
    wr(8'he6, 8'h48);
    wr(8'he6, 8'h88);
    // Bit 4 set turns an ending word into an ignored one, so line 2 stays in service.
    wr(8'he6, 8'h30);
    rd(8'he6, 8'h0c);
    wr(8'he6, 8'h20);
    rd(8'he6, 8'h08);
    wr(8'he6, 8'h62);
    rd(8'he6, 8'h08);
    wr(8'he6, 8'h63);
    rd(8'he6, 8'h00);
    wr(8'he6, 8'hc2);
    take(4'h0, 3'h3);
    wr(8'he6, 8'ha0);
    take(4'h1, 3'h2);
    wr(8'he6, 8'h20);
    take(4'h0, 3'h3);
    wr(8'he6, 8'h00);
    wr(8'he6, 8'h20);
    rsel(8'h0b, 8'h00);
    // With rotation off the ended line 3 keeps the top rank, so it wins again.
    take(4'h0, 3'h3);
    give_verdict();
  end
endmodule
`default_nettype wire
